/* hw/afs_pkg.sv */
// constants, field layouts and types for the audio fifo status block
// Summary of operation
// - receive fill count reported in bits 29:24
// - transmit fill count reported in bits 13:8
// - write into full receive fifo sets overrun
// - read from empty transmit fifo sets underrun
// - only flags writable; zero clears, one keeps
// - receive request high while count reaches threshold
// - transmit request high while count within threshold
// - requests drive interrupt or dma per enables
// - reserved bits ignore writes, read as zero
package afs_pkg;

    localparam int AFS_AW = 32;
    localparam int AFS_DW = 32;
    localparam int AFS_CW = 6;
    localparam int AFS_NB = 4;

    // register byte addresses
    localparam logic [31:0] AFS_STATUS_ADDR = 32'h1002_0014;
    localparam logic [31:0] AFS_CFG_ADDR    = 32'h1002_0100;
    localparam logic [31:0] AFS_EVT_ADDR    = 32'h1002_0104;
    localparam logic [31:0] AFS_MASK_ADDR   = 32'h1002_0108;

    localparam logic [31:0] AFS_STATUS_RST  = 32'h0000_0000;
    localparam logic [31:0] AFS_CFG_RST     = 32'h0000_0000;
    localparam logic [31:0] AFS_EVT_RST     = 32'h0000_0000;
    localparam logic [31:0] AFS_CFG_WMASK   = 32'h000F_3F3F;
    localparam logic [31:0] AFS_EVT_WMASK   = 32'h0000_0003;

    localparam logic [1:0]  AFS_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  AFS_RESP_SLVERR = 2'h2;

    localparam int AFS_NFLAG   = 2;
    localparam int AFS_FLAG_RX = 0;
    localparam int AFS_FLAG_TX = 1;

    // status register layout, msb first
    typedef struct packed {
        logic [1:0]        rsvd_31_30;
        logic [AFS_CW-1:0] rx_fill_count;
        logic [9:0]        rsvd_23_14;
        logic [AFS_CW-1:0] tx_fill_count;
        logic              rsvd_7;
        logic              rx_overflow_flag;
        logic              tx_starve_flag;
        logic              rx_service_request;
        logic              tx_service_request;
        logic [2:0]        rsvd_2_0;
    } afs_stat_t;

    // configuration register layout, msb first
    typedef struct packed {
        logic [11:0]       rsvd_31_20;
        logic              tx_dma_en;
        logic              rx_dma_en;
        logic              tx_irq_en;
        logic              rx_irq_en;
        logic [1:0]        rsvd_15_14;
        logic [AFS_CW-1:0] tx_threshold_field;
        logic [1:0]        rsvd_7_6;
        logic [AFS_CW-1:0] rx_threshold_field;
    } afs_cfg_t;

    // event status and mask layout
    typedef struct packed {
        logic [29:0]       rsvd_31_2;
        logic              tx_starve_evt;
        logic              rx_overflow_evt;
    } afs_evt_t;

endpackage

/* hw/afs_sticky_flag.sv */
// one sticky flag: hardware sets it, software clears it
`timescale 1ns/10ps
module afs_sticky_flag
    import afs_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // control
    input  wire logic set_evt,
    input  wire logic clr_req,
    // state
    output logic      flag_ff
);

    logic nxt_flag;

    // set wins so an event in the clearing cycle is kept
    assign nxt_flag = set_evt | (flag_ff & ~clr_req);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_ff <= 1'b0;
        end else if (clk_en) begin
            flag_ff <= nxt_flag;
        end
    end

endmodule

/* hw/afs_top.sv */
// fifo status register, service requests and axi4-lite slave
`timescale 1ns/10ps
module afs_top
    import afs_pkg::*;
(
    // clock, reset and enable
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    // axi4-lite write address
    input  wire logic [AFS_AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [AFS_DW-1:0] s_axi_wdata,
    input  wire logic [AFS_NB-1:0] s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [AFS_AW-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [AFS_DW-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // fifo state, same clock
    input  wire logic [AFS_CW-1:0] rx_fill_count,
    input  wire logic [AFS_CW-1:0] tx_fill_count,
    input  wire logic              rx_push,
    input  wire logic              rx_full,
    input  wire logic              tx_pop,
    input  wire logic              tx_empty,
    // requests
    output logic                   rx_dma_req,
    output logic                   tx_dma_req,
    output logic                   fifo_irq
);

    // bus state
    logic              awready_ff;
    logic              wready_ff;
    logic              aw_got_ff;
    logic              w_got_ff;
    logic [AFS_AW-1:0] awaddr_ff;
    logic [AFS_DW-1:0] wdata_ff;
    logic [AFS_NB-1:0] wstrb_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              arready_ff;
    logic              rvalid_ff;
    logic [AFS_DW-1:0] rdata_ff;
    logic [1:0]        rresp_ff;

    // block state
    afs_cfg_t          cfg_ff;
    afs_evt_t          evt_ff;
    afs_evt_t          mask_ff;
    logic              rx_sr_ff;
    logic              tx_sr_ff;
    logic              rx_dma_ff;
    logic              tx_dma_ff;
    logic              irq_ff;
    logic [AFS_NFLAG-1:0] flag_ff;

    // handshakes and next values
    wire               aw_hs = s_axi_awvalid & awready_ff;
    wire               w_hs  = s_axi_wvalid & wready_ff;
    wire               ar_hs = s_axi_arvalid & arready_ff;
    wire               wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire               nxt_aw_got = wr_go ? 1'b0 : (aw_got_ff | aw_hs);
    wire               nxt_w_got  = wr_go ? 1'b0 : (w_got_ff | w_hs);
    wire               nxt_bvalid = wr_go | (bvalid_ff & ~s_axi_bready);
    wire               nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);
    wire               nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
    wire               nxt_wready  = ~nxt_w_got & ~nxt_bvalid;
    wire               nxt_arready = ~nxt_rvalid;

    // write decode
    wire               wsel_status = wr_go & (awaddr_ff == AFS_STATUS_ADDR);
    wire               wsel_cfg    = wr_go & (awaddr_ff == AFS_CFG_ADDR);
    wire               wsel_mask   = wr_go & (awaddr_ff == AFS_MASK_ADDR);
    wire               wsel_evt    = wr_go & (awaddr_ff == AFS_EVT_ADDR);
    wire               wr_hit = wsel_status | wsel_cfg | wsel_mask | wsel_evt;

    // read decode
    wire               rsel_status = (s_axi_araddr == AFS_STATUS_ADDR);
    wire               rsel_cfg    = (s_axi_araddr == AFS_CFG_ADDR);
    wire               rsel_evt    = (s_axi_araddr == AFS_EVT_ADDR);
    wire               rsel_mask   = (s_axi_araddr == AFS_MASK_ADDR);
    wire               rd_hit = rsel_status | rsel_cfg | rsel_evt | rsel_mask;

    // byte-lane mask from the latched strobes
    logic [AFS_DW-1:0] lane_mask;
    genvar gb;
    generate
        for (gb = 0; gb < AFS_NB; gb++) begin : g_lane
            assign lane_mask[gb*8 +: 8] = {8{wstrb_ff[gb]}};
        end
    endgenerate

    wire [AFS_DW-1:0]  cfg_wmask = lane_mask & AFS_CFG_WMASK;
    wire [AFS_DW-1:0]  mask_wmask = lane_mask & AFS_EVT_WMASK;
    wire afs_cfg_t     nxt_cfg = afs_cfg_t'((cfg_ff & ~cfg_wmask)
                                 | (wdata_ff & cfg_wmask));
    wire afs_evt_t     nxt_mask = afs_evt_t'((mask_ff & ~mask_wmask)
                                  | (wdata_ff & mask_wmask));

    // flag clears: the flags live in byte lane 0
    wire afs_stat_t    wr_stat = afs_stat_t'(wdata_ff);
    wire               flag_lane = wsel_status & wstrb_ff[0];
    logic [AFS_NFLAG-1:0] flag_set;
    logic [AFS_NFLAG-1:0] flag_clr;
    assign flag_set[AFS_FLAG_RX] = rx_push & rx_full;
    assign flag_set[AFS_FLAG_TX] = tx_pop & tx_empty;
    // a written one leaves the flag alone
    assign flag_clr[AFS_FLAG_RX] = flag_lane
                                   & ~wr_stat.rx_overflow_flag;
    assign flag_clr[AFS_FLAG_TX] = flag_lane
                                   & ~wr_stat.tx_starve_flag;

    genvar gf;
    generate
        for (gf = 0; gf < AFS_NFLAG; gf++) begin : g_flag
            afs_sticky_flag u_flag (
                .core_clk (core_clk),
                .rst_b    (rst_b),
                .clk_en   (clk_en),
                .set_evt  (flag_set[gf]),
                .clr_req  (flag_clr[gf]),
                .flag_ff  (flag_ff[gf])
            );
        end
    endgenerate

    // status image; reserved fields tied to zero
    afs_stat_t         stat_img;
    always_comb begin
        stat_img                    = afs_stat_t'(AFS_STATUS_RST);
        stat_img.rx_fill_count      = rx_fill_count;
        stat_img.tx_fill_count      = tx_fill_count;
        stat_img.rx_overflow_flag   = flag_ff[AFS_FLAG_RX];
        stat_img.tx_starve_flag     = flag_ff[AFS_FLAG_TX];
        stat_img.rx_service_request = rx_sr_ff;
        stat_img.tx_service_request = tx_sr_ff;
    end

    // read data selection
    wire [AFS_DW-1:0]  rd_mux =
        rsel_status ? AFS_DW'(stat_img) :
        rsel_cfg    ? AFS_DW'(cfg_ff)   :
        rsel_evt    ? AFS_DW'(evt_ff)   :
        rsel_mask   ? AFS_DW'(mask_ff)  : AFS_STATUS_RST;

    // event status: set by flag events, cleared by a read of it
    wire               evt_rd_clr = ar_hs & rsel_evt;
    afs_evt_t          evt_set;
    always_comb begin
        evt_set                 = afs_evt_t'(AFS_EVT_RST);
        evt_set.rx_overflow_evt = flag_set[AFS_FLAG_RX];
        evt_set.tx_starve_evt   = flag_set[AFS_FLAG_TX];
    end
    // set wins over the read clear
    wire afs_evt_t     nxt_evt = afs_evt_t'(evt_set
                                 | (evt_ff & ~{AFS_DW{evt_rd_clr}}));

    // service requests from current fill counts
    wire               nxt_rx_sr = (rx_fill_count
                                    >= cfg_ff.rx_threshold_field);
    wire               nxt_tx_sr = (tx_fill_count
                                    <= cfg_ff.tx_threshold_field);

    // request fan-out: a request reaches the paths that are enabled
    wire               nxt_rx_dma = rx_sr_ff & cfg_ff.rx_dma_en;
    wire               nxt_tx_dma = tx_sr_ff & cfg_ff.tx_dma_en;
    wire               sr_irq = (rx_sr_ff & cfg_ff.rx_irq_en)
                                | (tx_sr_ff & cfg_ff.tx_irq_en);
    wire               nxt_irq = sr_irq | (|(evt_ff & mask_ff));

    // write channel
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= AFS_RESP_OKAY;
        end else if (clk_en) begin
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            aw_got_ff  <= nxt_aw_got;
            w_got_ff   <= nxt_w_got;
            bvalid_ff  <= nxt_bvalid;
            if (wr_go) begin
                bresp_ff <= wr_hit ? AFS_RESP_OKAY : AFS_RESP_SLVERR;
            end
        end
    end

    // latched write payload; address and data may come in either order
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awaddr_ff <= AFS_STATUS_RST;
            wdata_ff  <= AFS_STATUS_RST;
            wstrb_ff  <= '0;
        end else if (clk_en) begin
            if (aw_hs) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
        end
    end

    // read channel; data sampled when the address is taken
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= AFS_STATUS_RST;
            rresp_ff   <= AFS_RESP_OKAY;
        end else if (clk_en) begin
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            if (ar_hs) begin
                rdata_ff <= rd_mux;
                rresp_ff <= rd_hit ? AFS_RESP_OKAY : AFS_RESP_SLVERR;
            end
        end
    end

    // software registers; the event register is read-only to writes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff  <= afs_cfg_t'(AFS_CFG_RST);
            mask_ff <= afs_evt_t'(AFS_EVT_RST);
            evt_ff  <= afs_evt_t'(AFS_EVT_RST);
        end else if (clk_en) begin
            if (wsel_cfg) begin
                cfg_ff <= nxt_cfg;
            end
            if (wsel_mask) begin
                mask_ff <= nxt_mask;
            end
            evt_ff <= nxt_evt;
        end
    end

    // requests and interrupt, registered so every output is a flop
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_sr_ff  <= 1'b0;
            tx_sr_ff  <= 1'b0;
            rx_dma_ff <= 1'b0;
            tx_dma_ff <= 1'b0;
            irq_ff    <= 1'b0;
        end else if (clk_en) begin
            rx_sr_ff  <= nxt_rx_sr;
            tx_sr_ff  <= nxt_tx_sr;
            rx_dma_ff <= nxt_rx_dma;
            tx_dma_ff <= nxt_tx_dma;
            irq_ff    <= nxt_irq;
        end
    end

    // outputs
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign rx_dma_req    = rx_dma_ff;
    assign tx_dma_req    = tx_dma_ff;
    assign fifo_irq      = irq_ff;

    // prot bits carry no meaning for this slave
    wire               unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule

/* tb/afs_top_props.sv */
// concurrent checks on the fifo status block bus ports
`timescale 1ns/10ps
module afs_top_props
    import afs_pkg::*;
(
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst_b,
    // write side
    input wire logic [AFS_AW-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    // read side
    input wire logic [AFS_AW-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [AFS_DW-1:0] s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready
);
    logic [AFS_AW-1:0] rd_addr_ff;
    logic [AFS_AW-1:0] wr_addr_ff;
    wire  [AFS_AW-1:0] nxt_rd_addr;
    wire  [AFS_AW-1:0] nxt_wr_addr;
    assign nxt_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr
                                                          : rd_addr_ff;
    assign nxt_wr_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr
                                                          : wr_addr_ff;
    function automatic logic mapped(input logic [AFS_AW-1:0] a);
        return a inside {AFS_STATUS_ADDR, AFS_CFG_ADDR, AFS_EVT_ADDR,
                         AFS_MASK_ADDR};
    endfunction
    // remember the address so each response can be judged against it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_addr_ff <= '0;
            wr_addr_ff <= '0;
        end else begin
            rd_addr_ff <= nxt_rd_addr;
            wr_addr_ff <= nxt_wr_addr;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_lat: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late or early");
    a_aw_busy: assert property (s_wr_taken |=> !s_axi_awready [*2])
        else $error("write address accepted while busy");
    a_read_lat: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one cycle after address");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_rsv_zero: assert property (
        s_axi_rvalid && rd_addr_ff == AFS_STATUS_ADDR
        |-> (s_axi_rdata & 32'hC0FF_C087) == 32'h0)
        else $error("reserved status bits not zero");
    a_rd_slverr: assert property (s_axi_rvalid && !mapped(rd_addr_ff)
        |-> s_axi_rresp == AFS_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_rd_okay: assert property (s_axi_rvalid && mapped(rd_addr_ff)
        |-> s_axi_rresp == AFS_RESP_OKAY)
        else $error("mapped read refused");
    a_wr_resp: assert property (s_axi_bvalid |-> s_axi_bresp ==
        (mapped(wr_addr_ff) ? AFS_RESP_OKAY : AFS_RESP_SLVERR))
        else $error("write response code wrong");
endmodule
bind afs_top afs_top_props u_props (.core_clk(core_clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

/* tb/audio_fifo_status_tb_top.sv */
// self-checking bench for the fifo status block
`timescale 1ns/10ps
module audio_fifo_status_tb_top
    import afs_pkg::*;
;
    logic        core_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rd;
    logic [5:0]  rxc, txc;
    logic [3:0]  fev;
    logic [1:0]  resp;
    logic [3:0]  wstrb;
    logic        clk_en;
    wire  [31:0] rdata;
    wire  [1:0]  bresp, rresp;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         rx_dma, tx_dma, irq;
    int          n_mismatch, total_checks;
    afs_top uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_fill_count(rxc),
        .tx_fill_count(txc), .rx_push(fev[3]), .rx_full(fev[2]),
        .tx_pop(fev[1]), .tx_empty(fev[0]), .rx_dma_req(rx_dma),
        .tx_dma_req(tx_dma), .fifo_irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // expected status word: counts plus {ovf, starve, rx req, tx req}
    function logic [31:0] st(input logic [5:0] r, t, input logic [3:0] f);
        return {2'h0, r, 10'h0, t, 1'h0, f, 3'h0};
    endfunction
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic ad;
        logic wd;
        @(posedge core_clk);
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge core_clk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (bvalid !== 1'b1);
        // answer left waiting a cycle so the hold checks see it
        bready <= 1'b1;
        @(posedge core_clk);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task rdr(input logic [31:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (rvalid !== 1'b1);
        rready <= 1'b1;
        @(posedge core_clk);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task pulse(input logic [3:0] v);
        @(posedge core_clk);
        fev <= v;
        @(posedge core_clk);
        fev <= 4'h0;
        repeat (2) @(posedge core_clk);
    endtask
    task t_reset;
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h00, 6'h00, 4'h3));
        rdr(AFS_CFG_ADDR);
        chk(rd, AFS_CFG_RST);
        $display("test reset done");
    endtask
    task t_levels;
        logic [5:0] rv[4];
        logic [5:0] tv[4];
        rv = '{6'h0F, 6'h10, 6'h20, 6'h3F};
        tv = '{6'h09, 6'h08, 6'h00, 6'h3F};
        wr(AFS_CFG_ADDR, 32'h0000_0810);
        for (int i = 0; i < 4; i++) begin
            rxc <= rv[i];
            txc <= tv[i];
            repeat (3) @(posedge core_clk);
            rdr(AFS_STATUS_ADDR);
            chk(rd, st(rv[i], tv[i], {2'b00, rv[i] >= 6'h10,
                tv[i] <= 6'h08}));
        end
        $display("test levels done");
    endtask
    task t_flags;
        rxc <= 6'h00;
        txc <= 6'h00;
        pulse(4'b1010);
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h00, 6'h00, 4'h1));
        pulse(4'b1111);
        repeat (4) @(posedge core_clk);
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h00, 6'h00, 4'hD));
        wr(AFS_STATUS_ADDR, 32'hFFFF_FFFF);
        chk(32'(resp), 32'(AFS_RESP_OKAY));
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h00, 6'h00, 4'hD));
        wr(AFS_STATUS_ADDR, 32'hFFFF_FFBF);
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h00, 6'h00, 4'h5));
        wr(AFS_STATUS_ADDR, 32'h0000_0000);
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h00, 6'h00, 4'h1));
        $display("test flags done");
    endtask
    // enables route each request; event bits go through the mask
    task t_irq;
        rdr(AFS_EVT_ADDR);
        chk(rd, 32'h0000_0003);
        wr(AFS_CFG_ADDR, 32'h0005_0810);
        rxc <= 6'h10;
        txc <= 6'h08;
        repeat (4) @(posedge core_clk);
        chk(32'({rx_dma, tx_dma, irq}), 32'h5);
        wr(AFS_CFG_ADDR, 32'h000A_0810);
        repeat (3) @(posedge core_clk);
        chk(32'({rx_dma, tx_dma, irq}), 32'h3);
        rxc <= 6'h0F;
        txc <= 6'h09;
        repeat (4) @(posedge core_clk);
        chk(32'({rx_dma, tx_dma, irq}), 32'h0);
        wr(AFS_CFG_ADDR, 32'h0000_0000);
        wr(AFS_MASK_ADDR, 32'h0000_0001);
        pulse(4'b0011);
        chk(32'(irq), 32'h0);
        pulse(4'b1100);
        chk(32'(irq), 32'h1);
        rdr(AFS_EVT_ADDR);
        chk(rd, 32'h0000_0003);
        repeat (3) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        $display("test irq done");
    endtask
    task t_unmapped;
        wr(32'h1002_0000, 32'hFFFF_FFFF);
        chk(32'(resp), 32'(AFS_RESP_SLVERR));
        rdr(32'h1002_0000);
        chk(32'(resp), 32'(AFS_RESP_SLVERR));
        chk(rd, 32'h0000_0000);
        $display("test unmapped done");
    endtask
    // lane 0 gates flag clears; low enable freezes; reset clears
    task t_hold;
        wstrb <= 4'hE;
        wr(AFS_STATUS_ADDR, 32'h0000_0000);
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h0F, 6'h09, 4'hE));
        wstrb <= 4'hF;
        wr(AFS_STATUS_ADDR, 32'h0000_0000);
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h0F, 6'h09, 4'h2));
        clk_en <= 1'b0;
        pulse(4'b1111);
        clk_en <= 1'b1;
        rxc <= 6'h00;
        txc <= 6'h00;
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h00, 6'h00, 4'h3));
        rdr(AFS_EVT_ADDR);
        chk(rd, AFS_EVT_RST);
        pulse(4'b1111);
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h00, 6'h00, 4'hF));
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        rdr(AFS_STATUS_ADDR);
        chk(rd, st(6'h00, 6'h00, 4'h3));
        rdr(AFS_MASK_ADDR);
        chk(rd, AFS_EVT_RST);
        $display("test hold done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, wdata, araddr} = '0;
        {rxc, txc, fev} = '0;
        {clk_en, wstrb} = 5'h1F;
        n_mismatch = 0;
        total_checks = 0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset();
        t_levels();
        t_flags();
        t_irq();
        t_unmapped();
        t_hold();
        finish_test();
    end
    // whole run is well under a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule
